/* core/adsc_defines.svh */
// Constants shared by the converter serial control readout files.
`ifndef ADSC_DEFINES_SVH
`define ADSC_DEFINES_SVH
`define ADSC_ADDR_STATUS 6'h00
`define ADSC_ADDR_CTRL 6'h01
`define ADSC_ADDR_DATA 6'h02
`define ADSC_ADDR_W 6
`define ADSC_CTRL_RST 16'h0000
`define ADSC_CTRL_W 16
`define ADSC_STAT_W 8
`define ADSC_CMD_W 8
`define ADSC_CMD_RD 6
`define ADSC_CMD_EXIT {2'h1, `ADSC_ADDR_DATA}
`define ADSC_BIT_DEL 12
`define ADSC_BIT_CONT 11
`define ADSC_ONES_RESET 64
`define ADSC_EV_WR 0
`define ADSC_EV_EXIT 1
`define ADSC_EV_DONE 2
`define ADSC_EV_RST 3
`define ADSC_MCLK_NS 25
`define ADSC_DEL_SHORT_NS 10
`define ADSC_DEL_LONG_NS 100
`define ADSC_DEL_SHORT_CYC \
  ((`ADSC_DEL_SHORT_NS + `ADSC_MCLK_NS - 1) / `ADSC_MCLK_NS)
`define ADSC_DEL_LONG_CYC \
  ((`ADSC_DEL_LONG_NS + `ADSC_MCLK_NS - 1) / `ADSC_MCLK_NS)
`endif

/* core/adsc_pkg.sv */
// Types shared by the converter serial control readout files.
package adsc_pkg;
  typedef enum logic [1:0] {
    ADSC_CMD, ADSC_WRITE, ADSC_READ, ADSC_CREAD
  } adsc_phase_t;
endpackage

/* core/adsc_link_if.sv */
// Signals between the core clock domain and the serial link end.
`timescale 1ns/1ps
`include "adsc_defines.svh"
interface adsc_link_if #(parameter int DATA_W = 24);
  logic [`ADSC_CTRL_W-1:0] ctrl_word;
  logic [`ADSC_STAT_W-1:0] status_word;
  logic [DATA_W-1:0] data_word;
  logic [`ADSC_CTRL_W-1:0] wr_word;
  logic wr_tgl;
  logic exit_tgl;
  logic done_tgl;
  logic rst_tgl;
  logic show_tx;
  logic tx_bit;
  modport core (output ctrl_word, status_word, data_word,
    input wr_word, wr_tgl, exit_tgl, done_tgl, rst_tgl, show_tx, tx_bit);
  modport link (input ctrl_word, status_word, data_word,
    output wr_word, wr_tgl, exit_tgl, done_tgl, rst_tgl, show_tx, tx_bit);
endinterface // adsc_link_if

/* core/adsc_link.sv */
// Serial link end: command decode, register shifting and stream readout.
`timescale 1ns/1ps
`include "adsc_defines.svh"
module adsc_link
  import adsc_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input wire logic sclk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  adsc_link_if.link lk
);
  localparam int CW = $clog2(DATA_W + 1);
  localparam int SW = `ADSC_CTRL_W;
  adsc_phase_t phase, next_phase;
  logic [CW-1:0] rx_cnt, next_rx_cnt, word_len, next_word_len;
  logic [CW-1:0] tx_cnt, next_tx_cnt;
  logic [SW-1:0] rx_sr, next_rx_sr, wr_word, next_wr_word, sr_in;
  logic [DATA_W-1:0] tx_sr, next_tx_sr;
  logic [6:0] ones, next_ones;
  logic [5:0] sel, next_sel;
  logic exit_pend, next_exit_pend, reading;
  logic wr_tgl, next_wr_tgl, exit_tgl, next_exit_tgl;
  logic done_tgl, next_done_tgl, rst_tgl, next_rst_tgl;

  assign sr_in = {rx_sr[SW-2:0], din_i};
  assign reading = (phase == ADSC_READ) || (phase == ADSC_CREAD);

  // Rising edge: sample the input, decode commands, count ones.
  always_comb begin
    next_phase = phase;
    next_rx_cnt = rx_cnt;
    next_word_len = word_len;
    next_rx_sr = rx_sr;
    next_wr_word = wr_word;
    next_ones = ones;
    next_sel = sel;
    next_exit_pend = exit_pend;
    next_wr_tgl = wr_tgl;
    next_exit_tgl = exit_tgl;
    next_done_tgl = done_tgl;
    next_rst_tgl = rst_tgl;
    if (!cs_n_i) begin
      next_ones = din_i ? ones + 7'h01 : 7'h00;
      if (din_i && ones == 7'(`ADSC_ONES_RESET - 1)) begin
        next_phase = ADSC_CMD;
        next_rx_cnt = '0;
        next_exit_pend = 1'b0;
        next_ones = 7'h00;
        next_rst_tgl = ~rst_tgl;
      end else if (phase == ADSC_CMD) begin
        // A leading one is not taken as a command start.
        if (rx_cnt != '0 || !din_i) begin
          next_rx_sr = sr_in;
          next_rx_cnt = rx_cnt + 1'b1;
        end
        if (rx_cnt == CW'(`ADSC_CMD_W - 1)) begin
          next_rx_cnt = '0;
          next_sel = sr_in[`ADSC_ADDR_W-1:0];
          if (sr_in[`ADSC_CMD_RD]) begin
            if (sr_in[`ADSC_ADDR_W-1:0] == `ADSC_ADDR_DATA) begin
              next_phase = lk.ctrl_word[`ADSC_BIT_CONT] ? ADSC_CREAD
                : ADSC_READ;
              next_word_len = CW'(DATA_W);
            end else if (sr_in[`ADSC_ADDR_W-1:0] == `ADSC_ADDR_CTRL) begin
              next_phase = ADSC_READ;
              next_word_len = CW'(SW);
            end else if (sr_in[`ADSC_ADDR_W-1:0] == `ADSC_ADDR_STATUS) begin
              next_phase = ADSC_READ;
              next_word_len = CW'(`ADSC_STAT_W);
            end
          end else if (sr_in[`ADSC_ADDR_W-1:0] == `ADSC_ADDR_CTRL) begin
            next_phase = ADSC_WRITE;
          end
        end
      end else begin
        next_rx_sr = sr_in;
        next_rx_cnt = rx_cnt + 1'b1;
        if (phase == ADSC_WRITE) begin
          if (rx_cnt == CW'(SW - 1)) begin
            next_wr_word = sr_in;
            next_wr_tgl = ~wr_tgl;
            next_phase = ADSC_CMD;
            next_rx_cnt = '0;
          end
        end else begin
          if (phase == ADSC_CREAD && rx_cnt == CW'(`ADSC_CMD_W - 1)
              && sr_in[`ADSC_CMD_W-1:0] == `ADSC_CMD_EXIT) begin
            next_exit_pend = 1'b1;
            next_exit_tgl = ~exit_tgl;
          end
          if (rx_cnt == word_len - 1'b1) begin
            next_rx_cnt = '0;
            if (sel == `ADSC_ADDR_DATA) begin
              next_done_tgl = ~done_tgl;
            end
            // Stream mode re-arms itself with no new command.
            if (phase == ADSC_READ || next_exit_pend) begin
              next_phase = ADSC_CMD;
              next_exit_pend = 1'b0;
            end
          end
        end
      end
    end
  end

  // Rising edge registers of the link end.
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= ADSC_CMD;
      rx_cnt <= '0;
      word_len <= '0;
      rx_sr <= '0;
      wr_word <= '0;
      ones <= 7'h00;
      sel <= 6'h00;
      exit_pend <= 1'b0;
      wr_tgl <= 1'b0;
      exit_tgl <= 1'b0;
      done_tgl <= 1'b0;
      rst_tgl <= 1'b0;
    end else begin
      phase <= next_phase;
      rx_cnt <= next_rx_cnt;
      word_len <= next_word_len;
      rx_sr <= next_rx_sr;
      wr_word <= next_wr_word;
      ones <= next_ones;
      sel <= next_sel;
      exit_pend <= next_exit_pend;
      wr_tgl <= next_wr_tgl;
      exit_tgl <= next_exit_tgl;
      done_tgl <= next_done_tgl;
      rst_tgl <= next_rst_tgl;
    end
  end

  // Falling edge: load the word on its first bit, then shift MSB first.
  always_comb begin
    next_tx_sr = tx_sr;
    next_tx_cnt = tx_cnt;
    if (!reading) begin
      next_tx_cnt = '0;
    end else if (!cs_n_i) begin
      if (tx_cnt == '0) begin
        next_tx_sr = '0;
        if (sel == `ADSC_ADDR_CTRL) begin
          next_tx_sr[DATA_W-1 -: SW] = lk.ctrl_word;
        end else if (sel == `ADSC_ADDR_STATUS) begin
          next_tx_sr[DATA_W-1 -: `ADSC_STAT_W] = lk.status_word;
        end else begin
          next_tx_sr = lk.data_word;
        end
      end else begin
        next_tx_sr = {tx_sr[DATA_W-2:0], 1'b0};
      end
      next_tx_cnt = (tx_cnt == word_len - 1'b1) ? '0 : tx_cnt + 1'b1;
    end
  end

  // Falling edge registers of the link end.
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sr <= '0;
      tx_cnt <= '0;
    end else begin
      tx_sr <= next_tx_sr;
      tx_cnt <= next_tx_cnt;
    end
  end

  // A bit is on the pin from its falling edge to the next rising edge.
  assign lk.show_tx = reading && (tx_cnt != rx_cnt);
  assign lk.tx_bit = tx_sr[DATA_W-1];
  assign lk.wr_word = wr_word;
  assign lk.wr_tgl = wr_tgl;
  assign lk.exit_tgl = exit_tgl;
  assign lk.done_tgl = done_tgl;
  assign lk.rst_tgl = rst_tgl;

  wen_hold_a: assert property (
    @(posedge sclk_i) disable iff (!rst_n_i)
    phase == ADSC_CMD && rx_cnt == '0 && din_i && !cs_n_i
      && ones != 7'(`ADSC_ONES_RESET - 1)
    |=> phase == ADSC_CMD && rx_cnt == '0)
    else $error("leading one advanced the command");
  ones_reset_a: assert property (
    @(posedge sclk_i) disable iff (!rst_n_i)
    !cs_n_i && din_i && ones == 7'(`ADSC_ONES_RESET - 1)
    |=> phase == ADSC_CMD && rst_tgl != $past(rst_tgl))
    else $error("ones run did not reset the link");
  stream_stay_a: assert property (
    @(posedge sclk_i) disable iff (!rst_n_i)
    phase == ADSC_CREAD && !cs_n_i && !din_i && !exit_pend
      && rx_cnt == word_len - 1'b1
    |=> phase == ADSC_CREAD && rx_cnt == '0)
    else $error("stream mode left without exit command");
  din_watch_a: assert property (
    @(posedge sclk_i) disable iff (!rst_n_i)
    phase == ADSC_CREAD && !cs_n_i && !din_i |=> rx_sr[0] == 1'b0)
    else $error("input not watched in stream mode");
  ctrl_msb_a: assert property (
    @(negedge sclk_i) disable iff (!rst_n_i)
    phase == ADSC_READ && sel == `ADSC_ADDR_CTRL && tx_cnt == '0
      && !cs_n_i
    |=> lk.tx_bit == $past(lk.ctrl_word[SW-1]))
    else $error("control word not sent bit 15 first");
  stream_load_a: assert property (
    @(negedge sclk_i) disable iff (!rst_n_i)
    phase == ADSC_CREAD && tx_cnt == '0 && !cs_n_i
    |=> tx_cnt == CW'(1) && lk.tx_bit == $past(lk.data_word[DATA_W-1]))
    else $error("stream word not placed on the pin");
endmodule // adsc_link

/* core/adsc_serial_readout.sv */
// Serial control and result readout of a sigma-delta converter.
`timescale 1ns/1ps
`include "adsc_defines.svh"
module adsc_serial_readout
  import adsc_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_rdy_o,
  input wire logic conv_valid_i,
  output logic conv_ready_o,
  input wire logic [DATA_W-1:0] conv_data_i,
  input wire logic [3:0] conv_chan_i,
  output logic [`ADSC_CTRL_W-1:0] ctrl_o
);
  localparam int CHW = 4;
  localparam int EW = DATA_W + CHW;
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int DW = 3;
  logic [3:0] sy1, sy2, sy3, ev;
  logic [`ADSC_CTRL_W-1:0] ctrl, next_ctrl;
  logic [EW-1:0] mem [FIFO_DEPTH];
  logic [EW-1:0] head;
  logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic ready, next_ready, rdy, next_rdy, push, pop;
  logic [DATA_W-1:0] res_data, next_res_data;
  logic [CHW-1:0] res_chan, next_res_chan;
  logic [DW-1:0] del_cnt, next_del_cnt;

  adsc_link_if #(.DATA_W(DATA_W)) lk ();

  adsc_link #(.DATA_W(DATA_W)) u_link (
    .sclk_i(sclk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .lk(lk.link)
  );

  // Link events arrive as toggles; two flops then an edge compare.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy1 <= 4'h0;
      sy2 <= 4'h0;
      sy3 <= 4'h0;
    end else begin
      sy1 <= {lk.rst_tgl, lk.done_tgl, lk.exit_tgl, lk.wr_tgl};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end
  assign ev = sy2 ^ sy3;

  // Results queue here while the held result is still unread.
  assign head = mem[rd_ptr];
  assign push = conv_valid_i && ready;
  assign pop = (count != '0) && rdy && (del_cnt == '0);

  always_comb begin
    next_ctrl = ctrl;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_res_data = res_data;
    next_res_chan = res_chan;
    next_rdy = rdy;
    next_del_cnt = del_cnt;
    next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    next_ready = next_count != (PW + 1)'(FIFO_DEPTH);
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      {next_res_chan, next_res_data} = head;
      next_rdy = 1'b0;
    end
    // Hold ready low for the selected time after the result is read.
    if (ev[`ADSC_EV_DONE]) begin
      next_del_cnt = ctrl[`ADSC_BIT_DEL] ? DW'(`ADSC_DEL_LONG_CYC)
        : DW'(`ADSC_DEL_SHORT_CYC);
    end else if (del_cnt != '0) begin
      next_del_cnt = del_cnt - 1'b1;
      if (del_cnt == DW'(1)) begin
        next_rdy = 1'b1;
      end
    end
    if (ev[`ADSC_EV_WR]) begin
      next_ctrl = lk.wr_word;
    end
    if (ev[`ADSC_EV_EXIT]) begin
      next_ctrl[`ADSC_BIT_CONT] = 1'b0;
    end
    if (ev[`ADSC_EV_RST]) begin
      next_ctrl = `ADSC_CTRL_RST;
      next_rdy = 1'b1;
      next_del_cnt = '0;
    end
  end

  // Core registers; the queue storage itself needs no reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `ADSC_CTRL_RST;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      ready <= 1'b1;
      res_data <= '0;
      res_chan <= '0;
      rdy <= 1'b1;
      del_cnt <= '0;
    end else begin
      ctrl <= next_ctrl;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      ready <= next_ready;
      res_data <= next_res_data;
      res_chan <= next_res_chan;
      rdy <= next_rdy;
      del_cnt <= next_del_cnt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= {conv_chan_i, conv_data_i};
    end
  end

  // Words read by the link follow the core registers live; the link copies each one on a word's first bit.
  assign lk.ctrl_word = ctrl;
  assign lk.status_word = {rdy, 3'h0, res_chan};
  assign lk.data_word = res_data;

  // The pin carries the shifted bit, otherwise the ready level.
  assign dout_rdy_o = lk.show_tx ? lk.tx_bit : rdy;
  assign conv_ready_o = ready;
  assign ctrl_o = ctrl;

  ctrl_reset_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ev[`ADSC_EV_RST] |=> ctrl == `ADSC_CTRL_RST && rdy)
    else $error("serial reset did not clear control");
  release_long_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ev[`ADSC_EV_DONE] && ctrl[`ADSC_BIT_DEL] && !rdy
      && !ev[`ADSC_EV_RST]
    |=> !rdy [*4] ##1 rdy)
    else $error("long ready release time wrong");
  release_short_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ev[`ADSC_EV_DONE] && !ctrl[`ADSC_BIT_DEL] && !rdy
      && !ev[`ADSC_EV_RST]
    |=> !rdy ##1 rdy)
    else $error("short ready release time wrong");
  ready_fall_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pop && !ev[`ADSC_EV_RST] |=> !rdy && res_data == $past(head[DATA_W-1:0]))
    else $error("new result did not pull ready low");
  chan_field_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pop |=> lk.status_word[CHW-1:0] == $past(head[EW-1 -: CHW]))
    else $error("status channel field wrong");
  stream_exit_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ev[`ADSC_EV_EXIT] |=> !ctrl[`ADSC_BIT_CONT])
    else $error("exit command left stream mode set");
  queue_full_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    count == (PW + 1)'(FIFO_DEPTH) && !pop |=> !conv_ready_o)
    else $error("full queue still accepted a result");
endmodule // adsc_serial_readout

/* testbench/adsc_host_model.sv */
// Host serial master model that frames commands and words on the link.
`timescale 1ns/1ps
module adsc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  // The link clock idles high and only runs inside a frame.
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  // One frame: tx goes out MSB first, and the pin is sampled at each rise.
  // The pin is also sampled 9 ns and 99 ns after the last rise.
  task automatic frame(input logic [63:0] tx, input int n,
      output logic [63:0] rx, output logic p_short, output logic p_long);
    rx = '0;
    #7 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #32 sclk_o = 1'b0;
      din_o = tx[i]; // Bits go out MSB first.
      #32 rx = {rx[62:0], dout_i};
      sclk_o = 1'b1;
    end
    #9 p_short = dout_i;
    din_o = 1'b0; // The input idles low between commands.
    #90 p_long = dout_i;
    cs_n_o = 1'b1;
  endtask
endmodule // adsc_host_model

/* testbench/adsc_serial_readout_tb.sv */
// Self-checking bench for the converter serial control readout block.
`timescale 1ns/1ps
`include "adsc_defines.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module adsc_serial_readout_tb
  import adsc_pkg::*;
;
  logic mclk_i, rst_n_i, sclk_i, cs_n_i, din_i, dout_rdy_o;
  logic conv_valid_i, conv_ready_o;
  logic [23:0] conv_data_i;
  logic [3:0] conv_chan_i;
  logic [15:0] ctrl_o;
  logic [63:0] rx;
  logic ps, pl;
  logic [27:0] exp_q[$];
  int miscompares, num_checks, cycles, rdy_hi;

  adsc_serial_readout #(.DATA_W(24), .FIFO_DEPTH(2)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .din_i(din_i), .dout_rdy_o(dout_rdy_o), .conv_valid_i(conv_valid_i),
    .conv_ready_o(conv_ready_o), .conv_data_i(conv_data_i),
    .conv_chan_i(conv_chan_i), .ctrl_o(ctrl_o));

  adsc_host_model u_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i),
    .dout_i(dout_rdy_o));

  // The core clock runs at 40 MHz.
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // A hang is cut short after a fixed number of core cycles.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      wrap_up();
    end
  end

  // Counts high ready levels seen while the link clock is high, inside or outside a frame.
  always @(negedge mclk_i) begin
    if (sclk_i === 1'b1 && dout_rdy_o === 1'b1)
      rdy_hi++;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One link frame through the host model.
  task automatic xfer(input logic [63:0] tx, input int n);
    u_host.frame(tx, n, rx, ps, pl);
  endtask

  // Writes the control register, then lets the word cross.
  task automatic wr_ctrl(input logic [15:0] w);
    xfer({40'h0, 2'b00, `ADSC_ADDR_CTRL, w}, 24);
    repeat (8) @(negedge mclk_i);
  endtask

  // Reads the control register back over the link.
  task automatic rd_ctrl(input logic [15:0] ex);
    xfer({40'h0, 2'b01, `ADSC_ADDR_CTRL, 16'h0}, 24);
    `CHK("ctrl_read", ex, rx[15:0])
  endtask

  // Waits, bounded, until the shared pin shows the given ready level.
  task automatic wait_rdy(input logic v);
    for (int i = 0; i < 4000; i++) begin
      @(negedge mclk_i);
      if (dout_rdy_o === v)
        break;
    end
    `CHK("ready_pin", v, dout_rdy_o)
  endtask

  // Offers one random result and holds it until the queue takes it.
  task automatic push();
    logic [27:0] v;
    v = {4'($urandom), 24'($urandom)};
    exp_q.push_back(v);
    @(posedge mclk_i);
    conv_valid_i <= 1'b1;
    conv_chan_i <= v[27:24];
    conv_data_i <= v[23:0];
    for (int i = 0; i < 100; i++) begin
      @(negedge mclk_i);
      if (conv_ready_o === 1'b1)
        break;
    end
    @(posedge mclk_i);
    conv_valid_i <= 1'b0;
  endtask

  // Reads one result frame and checks the word and the pin release.
  task automatic get_result(input logic [63:0] tx, input int n,
      input logic d);
    logic [27:0] ex;
    int base;
    wait_rdy(1'b0);
    base = rdy_hi;
    xfer(tx, n);
    ex = exp_q.pop_front();
    `CHK("result", ex[23:0], rx[23:0])
    `CHK("release_short", 1'b0, ps)
    if (d)
      `CHK("release_long", 1'b0, pl)
    // Ready may stand high for one core cycle only when a result waits.
    for (int i = 0; i < 4000 && rdy_hi == base; i++)
      @(negedge mclk_i);
    `CHK("ready_rise", 1'b1, rdy_hi != base)
  endtask

  // Main sequence.
  initial begin
    logic [15:0] w;
    rst_n_i = 1'b0;
    conv_valid_i = 1'b0;
    conv_data_i = 24'h0;
    conv_chan_i = 4'h0;
    void'($urandom(68));
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    `CHK("ctrl_reset", `ADSC_CTRL_RST, ctrl_o)
    `CHK("pin_reset", 1'b1, dout_rdy_o)
    `CHK("room_reset", 1'b1, conv_ready_o)
    rd_ctrl(`ADSC_CTRL_RST);
    for (int d = 0; d < 2; d++) begin
      w = {3'h0, d[0], 1'b0, 11'($urandom)};
      wr_ctrl(w);
      `CHK("ctrl_out", w, ctrl_o)
      xfer({56'h0, 2'b01, 6'h3f}, 8);
      rd_ctrl(w);
      repeat (3) push();
      repeat (4) @(negedge mclk_i);
      `CHK("queue_full", 1'b0, conv_ready_o)
      repeat (3) begin
        wait_rdy(1'b0);
        xfer({48'h0, 2'b01, `ADSC_ADDR_STATUS, 8'h0}, 16);
        `CHK("status", {4'h0, exp_q[0][27:24]}, rx[7:0])
        get_result({32'h0, 2'b01, `ADSC_ADDR_DATA, 24'h0}, 32, d[0]);
      end
    end
    // Stream mode: enter, read without a command, then leave.
    wr_ctrl(16'h0800);
    repeat (2) push();
    get_result({32'h0, `ADSC_CMD_EXIT, 24'h0}, 32, 1'b0);
    get_result(64'h0, 24, 1'b0);
    push();
    get_result({40'h0, `ADSC_CMD_EXIT, 16'h0}, 24, 1'b0);
    repeat (8) @(negedge mclk_i);
    `CHK("stream_off", 1'b0, ctrl_o[`ADSC_BIT_CONT])
    rd_ctrl(16'h0000);
    // Sixty-four ones on the input reset the link, the control register and the ready level, but not the result queue.
    wr_ctrl(16'h17bc);
    push();
    wait_rdy(1'b0);
    xfer({64{1'b1}}, 64);
    repeat (8) @(negedge mclk_i);
    `CHK("ctrl_ones", 16'h0000, ctrl_o)
    `CHK("pin_ones", 1'b1, dout_rdy_o)
    // The held result is dropped from the model once ready is forced high.
    void'(exp_q.pop_front());
    rd_ctrl(16'h0000);
    wrap_up();
  end
endmodule // adsc_serial_readout_tb
